// File: hdl/tmr_pkg.sv
// constants, field layout and carrier types for the 16-bit timer/counter
// assumes a 32-bit classic wishbone slave, byte-wide registers in bits 7:0
package tmr_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADR_CTL  = 8'h00;
  localparam logic [7:0] ADR_LOW  = 8'h04;
  localparam logic [7:0] ADR_HIGH = 8'h08;
  localparam logic [7:0] ADR_FLG  = 8'h0c;
  localparam logic [7:0] ADR_ENA  = 8'h10;
  localparam logic [7:0] ADR_PRI  = 8'h14;
  localparam logic [7:0] ADR_GIC  = 8'h18;
  // ==========================================================
  // counter_control field positions, and the flag/enable interrupt bit
  localparam int CTL_RUN  = 0;
  localparam int CTL_CS   = 1;
  localparam int CTL_SDIS = 2;
  localparam int CTL_OSC  = 3;
  localparam int CTL_PS   = 4;
  localparam int CTL_LPR  = 6;
  localparam int CTL_SIXTEEN_BIT_ACCESS_MODE = 7;
  localparam int IRQ_BIT  = 0;
  // ==========================================================
  // reset values and constants
  localparam logic [7:0]  CTL_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [2:0]  PSC_RST = 3'h0;
  localparam logic [3:0]  SEV_MODE = 4'hb;
  // ==========================================================
  // compare unit trigger carrier
  typedef struct packed {
    logic [3:0] mode;
    logic       sev;
    logic       unit2;
  } cmp_trig_t;
  // whole state of the block
  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0]  hbuf;
    logic [7:0]  ctl;
    logic        flag;
    logic        ena;
    logic        pri;
    logic [7:0]  gic;
    logic [2:0]  psc;
    logic        sync1;
    logic        sync2;
    logic        prev;
    logic        armed;
    logic        ack;
    logic [31:0] dat;
    logic        adc;
  } tmr_state_t;
endpackage

// File: hdl/tmr_counter.sv
// 16-bit timer/counter with prescaler, overflow flag and trigger reset
// assumes pins are synchronous to sys_clk_i and a classic wishbone master
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// RULE1 - count up, wrap ffff to 0000
// RULE2 - overflow latches the overflow flag bit 0
// RULE3 - interrupt only when enable bit 0 set
// RULE4 - mode 1011 trigger resets the counter
// RULE5 - second unit trigger starts conversion if enabled
// RULE6 - trigger reset only in synchronous modes
// RULE7 - compare pair acts as period
// RULE8 - counter write beats simultaneous trigger reset
// RULE9 - trigger reset never sets overflow flag
// RULE10 - async: wait falling edge after write
// RULE11 - late update skips next rising edge
// RULE12 - software preloads for one-second overflows
// RULE13 - software sets only high msb
// RULE14 - rtc needs async, irq enabled, oscillator on
// RULE15 - late software polls low byte first
// RULE16 - source select: cycle clock or edges
// RULE17 - prescale 1,2,4,8 from two bits
// RULE18 - 16-bit mode buffers high byte
// RULE19 - only low byte write clears prescaler
// RULE20 - flag sticks until software clears it
// RULE21 - optional synchroniser on external input
module tmr_counter (
  input  wire logic              sys_clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  input  wire logic              ext_clk_i,
  input  wire logic              lp_osc_i,
  input  wire logic              lp_sys_clk_i,
  input  wire tmr_pkg::cmp_trig_t trig_i,
  input  wire logic              adc_enable_i,
  output logic                   adc_start_o,
  output logic                   irq_o
);
  tmr_pkg::tmr_state_t s_r;
  tmr_pkg::tmr_state_t s_nxt;
  logic       take;
  logic       wr;
  logic       rd;
  logic       wr_lo;
  logic       wr_hi;
  logic       wr_flg;
  logic       sixteen_bit_access_mode;
  logic       async_m;
  logic       src;
  logic       lvl;
  logic       rise;
  logic       fall;
  logic       inc_evt;
  logic [2:0] lim;
  logic       tick;
  logic       ovf;
  logic       sev_ok;
  logic       sev_rst;
  logic       cnt_wr;
  logic [7:0] rdv;

  // ==========================================================
  // bus decode; side effects happen on the cycle the request is taken
  // ack is registered and masks take, so a master that holds stb through
  // the ack cycle is never served twice
  assign take   = cyc_i & stb_i & ~s_r.ack;
  assign wr     = take & we_i & sel_i[0];
  assign rd     = take & ~we_i;
  assign wr_lo  = wr & (adr_i == tmr_pkg::ADR_LOW);
  assign wr_hi  = wr & (adr_i == tmr_pkg::ADR_HIGH);
  assign wr_flg = wr & (adr_i == tmr_pkg::ADR_FLG);
  assign sixteen_bit_access_mode   = s_r.ctl[tmr_pkg::CTL_SIXTEEN_BIT_ACCESS_MODE];
  assign cnt_wr = wr_lo | (wr_hi & ~sixteen_bit_access_mode);

  // ==========================================================
  // count source: oscillator or pin, optional two-flop synchroniser
  // only sync2 reads sync1; all other users of the pin go through lvl
  // prev follows lvl every cycle, so a source switch can fake one edge
  assign src     = s_r.ctl[tmr_pkg::CTL_OSC] ? lp_osc_i : ext_clk_i;
  assign lvl     = s_r.ctl[tmr_pkg::CTL_SDIS] ? src : s_r.sync2; // RULE21
  assign rise    = lvl & ~s_r.prev;
  assign fall    = ~lvl & s_r.prev;
  assign async_m = s_r.ctl[tmr_pkg::CTL_CS] & s_r.ctl[tmr_pkg::CTL_SDIS];
  // internal source counts every cycle; external counts rising edges
  // in async mode a counter update disarms until the input falls again
  assign inc_evt = s_r.ctl[tmr_pkg::CTL_RUN] &
                   (s_r.ctl[tmr_pkg::CTL_CS] ? (rise & (~async_m | s_r.armed)) // RULE10 RULE11
                                             : 1'b1); // RULE16
  // prescale limit 0,1,3,7 for divide by 1,2,4,8
  assign lim  = 3'((4'h1 << s_r.ctl[tmr_pkg::CTL_PS +: 2]) - 4'h1); // RULE17
  assign tick = inc_evt & (s_r.psc == lim);
  assign ovf  = tick & (s_r.cnt == tmr_pkg::CNT_MAX) & ~cnt_wr & ~sev_rst;
  // trigger is unreliable with an unsynchronised clock, so its counter reset is ignored there
  assign sev_ok  = trig_i.sev & (trig_i.mode == tmr_pkg::SEV_MODE); // RULE4
  assign sev_rst = sev_ok & ~async_m; // RULE6 RULE7

  // ==========================================================
  // read mux; the status bit is live, not stored
  // unmapped addresses answer with zero, so probing software sees no fault
  always_comb begin
    unique case (adr_i)
      tmr_pkg::ADR_CTL:  rdv = {s_r.ctl[7], lp_sys_clk_i, s_r.ctl[5:0]};
      tmr_pkg::ADR_LOW:  rdv = s_r.cnt[7:0];
      tmr_pkg::ADR_HIGH: rdv = sixteen_bit_access_mode ? s_r.hbuf : s_r.cnt[15:8]; // RULE18
      tmr_pkg::ADR_FLG:  rdv = {7'h00, s_r.flag};
      tmr_pkg::ADR_ENA:  rdv = {7'h00, s_r.ena};
      tmr_pkg::ADR_PRI:  rdv = {7'h00, s_r.pri};
      tmr_pkg::ADR_GIC:  rdv = s_r.gic;
      default:           rdv = 8'h00;
    endcase
  end

  // ==========================================================
  // next state
  // counter priority: software write, then trigger reset, then increment;
  // the prescaler is reset only by a low byte write
  always_comb begin
    s_nxt       = s_r;
    s_nxt.ack   = take;
    s_nxt.dat   = rd ? {24'h000000, rdv} : 32'h00000000;
    s_nxt.sync1 = src;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev  = lvl;
    s_nxt.adc   = sev_ok & trig_i.unit2 & adc_enable_i; // RULE5
    if (fall) begin
      s_nxt.armed = 1'b1; // RULE10
    end
    if (inc_evt) begin
      s_nxt.psc = tick ? tmr_pkg::PSC_RST : s_r.psc + 3'h1;
    end
    // plain registers
    if (wr & (adr_i == tmr_pkg::ADR_CTL)) begin
      s_nxt.ctl = dat_i[7:0] & 8'hbf;
    end
    if (wr & (adr_i == tmr_pkg::ADR_ENA)) begin
      s_nxt.ena = dat_i[tmr_pkg::IRQ_BIT];
    end
    if (wr & (adr_i == tmr_pkg::ADR_PRI)) begin
      s_nxt.pri = dat_i[tmr_pkg::IRQ_BIT];
    end
    if (wr & (adr_i == tmr_pkg::ADR_GIC)) begin
      s_nxt.gic = dat_i[7:0];
    end
    // in 16-bit mode a low byte read snapshots the high byte
    if (rd & (adr_i == tmr_pkg::ADR_LOW) & sixteen_bit_access_mode) begin
      s_nxt.hbuf = s_r.cnt[15:8]; // RULE18
    end
    if (wr_hi & sixteen_bit_access_mode) begin
      s_nxt.hbuf = dat_i[7:0]; // RULE18
    end
    // counter: write first, then trigger reset, then increment
    if (wr_lo) begin
      s_nxt.cnt   = {sixteen_bit_access_mode ? s_r.hbuf : s_r.cnt[15:8], dat_i[7:0]}; // RULE8 RULE18
      s_nxt.psc   = tmr_pkg::PSC_RST; // RULE19
      s_nxt.armed = 1'b0; // RULE10
    end else if (wr_hi & ~sixteen_bit_access_mode) begin
      s_nxt.cnt[15:8] = dat_i[7:0]; // RULE8
      s_nxt.armed     = 1'b0; // RULE11
    end else if (sev_rst) begin
      s_nxt.cnt = tmr_pkg::CNT_RST; // RULE4 RULE9
    end else if (tick) begin
      s_nxt.cnt = s_r.cnt + 16'h0001; // RULE1
    end
    // flag: a software clear loses to an overflow in the same cycle
    if (wr_flg) begin
      s_nxt.flag = dat_i[tmr_pkg::IRQ_BIT];
    end
    if (ovf) begin
      s_nxt.flag = 1'b1; // RULE2 RULE20
    end
  end

  // ==========================================================
  // state register
  // reset clears the whole struct; named fields restate their reset values
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r       <= '0;
      s_r.cnt   <= tmr_pkg::CNT_RST;
      s_r.ctl   <= tmr_pkg::CTL_RST;
      s_r.psc   <= tmr_pkg::PSC_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dat_o       = s_r.dat;
  assign ack_o       = s_r.ack;
  assign adc_start_o = s_r.adc;
  assign irq_o       = s_r.flag & s_r.ena; // RULE3

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_wrap_zero: assert property ( // RULE1
    tick && s_r.cnt == 16'hffff && !cnt_wr && !sev_rst |=> s_r.cnt == 16'h0000)
    else $error("counter did not wrap to zero");
  chk_ovf_flag: assert property (ovf |=> s_r.flag && irq_o == s_r.ena) // RULE2
    else $error("overflow did not set flag");
  chk_irq_gate: assert property (!s_r.ena |-> !irq_o) // RULE3
    else $error("interrupt without enable");
  chk_sev_reset: assert property ( // RULE4
    sev_ok && !async_m && !cnt_wr |=> s_r.cnt == 16'h0000)
    else $error("trigger did not reset counter");
  chk_adc_start: assert property ( // RULE5
    sev_ok && trig_i.unit2 && adc_enable_i |=> adc_start_o ##1 !adc_start_o || $past(sev_ok))
    else $error("conversion start missing");
  chk_async_ignore: assert property ( // RULE6
    sev_ok && async_m && !cnt_wr && !tick |=> $stable(s_r.cnt))
    else $error("trigger acted in async mode");
  chk_write_wins: assert property ( // RULE8
    wr_lo && sev_ok |=> s_r.cnt[7:0] == $past(dat_i[7:0]))
    else $error("trigger beat counter write");
  chk_sev_noflag: assert property ( // RULE9
    sev_rst && !s_r.flag && !wr_flg |=> !s_r.flag)
    else $error("trigger set the flag");
  chk_arm_gate: assert property (async_m && !s_r.armed |-> !inc_evt) // RULE10
    else $error("counted before arming");
  chk_psc_clear: assert property (wr_lo |=> s_r.psc == 3'h0) // RULE19
    else $error("prescaler not cleared");
  chk_flag_sticky: assert property (s_r.flag && !wr_flg |=> s_r.flag) // RULE20
    else $error("flag dropped by itself");
  chk_int_count: assert property ( // RULE16
    s_r.ctl[1:0] == 2'b01 && !cnt_wr && !sev_rst && s_r.ctl[5:4] == 2'b00
    |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
    else $error("internal clock did not count");

  // ==========================================================
  // checks: interrupt flag and request
  // the flag may only rise from a real rollover or a software write of one
  // a trigger reset must never be the cause
  chk_flag_source: assert property ( // RULE9
    $rose(s_r.flag) |-> $past(ovf) || $past(wr_flg))
    else $error("flag rose without overflow");
  chk_irq_follow: assert property (s_r.flag && s_r.ena |-> irq_o) // RULE3
    else $error("enabled flag gave no interrupt");
  chk_flag_clear: assert property ( // RULE20
    wr_flg && !dat_i[tmr_pkg::IRQ_BIT] && !ovf |=> !s_r.flag)
    else $error("software clear ignored");
  chk_set_wins: assert property (wr_flg && ovf |=> s_r.flag) // RULE2
    else $error("clear beat overflow");

  // ==========================================================
  // checks: 16-bit access through the high byte buffer
  // the buffer keeps a rollover between byte reads from tearing the value
  chk_hbuf_snap: assert property ( // RULE18
    rd && adr_i == tmr_pkg::ADR_LOW && sixteen_bit_access_mode |=> s_r.hbuf == $past(s_r.cnt[15:8]))
    else $error("low read did not snapshot high byte");
  chk_hbuf_load: assert property ( // RULE18
    wr_lo && sixteen_bit_access_mode |=> s_r.cnt[15:8] == $past(s_r.hbuf))
    else $error("low write did not load buffered high byte");
  chk_hbuf_only: assert property ( // RULE18
    wr_hi && sixteen_bit_access_mode && !sev_rst && !tick |=> $stable(s_r.cnt))
    else $error("buffered high write reached the counter");

  // ==========================================================
  // checks: count source and prescaler
  // the limit is spelled out bit by bit, apart from the shift used above
  chk_psc_limit: assert property ( // RULE17
    tick |-> s_r.psc == {s_r.ctl[5:4] == 2'b11, s_r.ctl[5], |s_r.ctl[5:4]})
    else $error("prescaler ended at the wrong count");
  chk_psc_keep: assert property ( // RULE19
    wr_hi && !inc_evt |=> $stable(s_r.psc))
    else $error("high write touched the prescaler");
  chk_run_stop: assert property ( // RULE16
    !s_r.ctl[tmr_pkg::CTL_RUN] && !cnt_wr && !sev_rst |=> $stable(s_r.cnt))
    else $error("stopped counter moved");
  chk_ext_edge: assert property ( // RULE16
    s_r.ctl[1:0] == 2'b11 && !rise && !cnt_wr && !sev_rst |=> $stable(s_r.cnt))
    else $error("external count without a rising edge");
  chk_sync_delay: assert property ( // RULE21
    rise && s_r.ctl[2:1] == 2'b01 |-> $past(src, 2))
    else $error("synchronised edge arrived early");

  // ==========================================================
  // checks: asynchronous arming, trigger and conversion start
  // the trigger reset is ignored in async mode, so only arming is checked there
  chk_late_skip: assert property (async_m && cnt_wr |=> !s_r.armed) // RULE11
    else $error("update left counting armed");
  chk_arm_fall: assert property ( // RULE10
    async_m && fall && !cnt_wr |=> s_r.armed)
    else $error("falling edge did not arm");
  chk_other_mode: assert property ( // RULE4
    trig_i.sev && trig_i.mode != tmr_pkg::SEV_MODE && !cnt_wr && !tick |=> $stable(s_r.cnt))
    else $error("trigger in another mode reset the counter");
  chk_adc_gate: assert property (!adc_enable_i |=> !adc_start_o) // RULE5
    else $error("conversion start while converter off");
  chk_adc_unit: assert property (!trig_i.unit2 |=> !adc_start_o) // RULE5
    else $error("conversion start from the wrong unit");

  // ==========================================================
  // covers of the main scenarios
  cov_ovf: cover property (ovf);
  cov_sev: cover property (sev_rst ##1 s_r.cnt == 16'h0000);
  cov_adc: cover property (adc_start_o);
  cov_arm: cover property (async_m && fall ##[1:20] inc_evt);
  cov_rtc: cover property (s_r.ctl[3:0] == 4'hf && ovf);
endmodule

// File: sim/tmr_counter_tb_top.sv
// self-checking bench for the 16-bit timer/counter, random and corner cases
// assumes tmr_pkg and tmr_counter are compiled first; bus is classic wishbone
`timescale 1ns/1ps
module tmr_counter_tb_top;
  // ==========================================================
  // stimulus and observation signals
  logic               sys_clk_i = 1'b0;
  logic               arst_n_i  = 1'b0;
  logic               cyc_r     = 1'b0;
  logic               stb_r     = 1'b0;
  logic               we_r      = 1'b0;
  logic               ext_r     = 1'b0;
  logic               adc_en_r  = 1'b0;
  logic [7:0]         adr_r     = 8'h00;
  logic [31:0]        dat_r     = 32'h0;
  tmr_pkg::cmp_trig_t trig_r    = '0;
  logic [31:0]        dat_o;
  logic               ack_o;
  logic               adc_start_o;
  logic               irq_o;
  logic               osc_r     = 1'b0;
  logic               lps_r     = 1'b0;
  logic               use_osc   = 1'b0;
  logic [31:0]        rnd       = 32'h54e32a62;
  logic [7:0]         q;
  logic [7:0]         h;
  int                 mismatches = 0;
  int                 tests_run  = 0;
  int                 pulses     = 0;
  int                 p;
  int                 polls;

  tmr_counter u_dut (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .cyc_i(cyc_r), .stb_i(stb_r),
    .we_i(we_r), .adr_i(adr_r), .sel_i(4'hf), .dat_i(dat_r), .dat_o(dat_o),
    .ack_o(ack_o), .ext_clk_i(ext_r), .lp_osc_i(osc_r), .lp_sys_clk_i(lps_r),
    .trig_i(trig_r), .adc_enable_i(adc_en_r), .adc_start_o(adc_start_o),
    .irq_o(irq_o)
  );

  // ==========================================================
  // clock, and a tally of conversion-start cycles
  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (adc_start_o === 1'b1) pulses <= pulses + 1;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic wrap_up();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one wishbone cycle; s raises a trigger on the same edge the request is taken
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic s);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    cyc_r <= 1'b1;
    stb_r <= 1'b1;
    we_r <= w;
    adr_r <= a;
    dat_r <= {24'h0, d};
    trig_r.sev <= s;
    do begin
      @(posedge sys_clk_i);
      trig_r.sev <= 1'b0;
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o[7:0];
    cyc_r <= 1'b0;
    stb_r <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask
  task automatic rc(input logic [7:0] a, input string nm, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 1'b0);
    chk(nm, q, e);
  endtask
  // slow edges on the pin or the oscillator so the synchroniser sees each level
  task automatic ext(input logic v);
    @(posedge sys_clk_i);
    if (use_osc) osc_r <= v;
    else ext_r <= v;
    repeat (3) @(posedge sys_clk_i);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    for (int a = 0; a < 8; a++) rc(8'(a * 4), "reset value", 8'h00);
    wr(8'h1c, 8'hff);
    rc(8'h1c, "unmapped", 8'h00);
    rnd = xs(rnd);
    wr(tmr_pkg::ADR_GIC, rnd[7:0]);
    rc(tmr_pkg::ADR_GIC, "global ctl", rnd[7:0]);
    wr(tmr_pkg::ADR_CTL, 8'hff);
    rc(tmr_pkg::ADR_CTL, "ctl status bit", 8'hbf);
    // rollover from fff0 with the interrupt masked, then unmasked
    wr(tmr_pkg::ADR_CTL, 8'h00);
    wr(tmr_pkg::ADR_HIGH, 8'hff);
    wr(tmr_pkg::ADR_LOW, 8'hf0);
    wr(tmr_pkg::ADR_CTL, 8'h01);
    repeat (40) @(posedge sys_clk_i);
    wr(tmr_pkg::ADR_CTL, 8'h00);
    rc(tmr_pkg::ADR_HIGH, "wrapped high", 8'h00);
    bus(1'b0, tmr_pkg::ADR_LOW, 8'h00, 1'b0);
    chk("wrapped low small", {7'h0, q < 8'h40}, 8'h01);
    rc(tmr_pkg::ADR_FLG, "flag", 8'h01);
    chk("irq masked", {7'h0, irq_o}, 8'h00);
    wr(tmr_pkg::ADR_ENA, 8'h01);
    @(posedge sys_clk_i);
    chk("irq enabled", {7'h0, irq_o}, 8'h01);
    wr(tmr_pkg::ADR_FLG, 8'h00);
    @(posedge sys_clk_i);
    chk("irq cleared", {7'h0, irq_o}, 8'h00);
    // triggers with the reset mode and with random other modes
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      h = rnd[7:0] | 8'h10;
      trig_r.mode <= (i < 2) ? tmr_pkg::SEV_MODE :
                     ((rnd[11:8] == tmr_pkg::SEV_MODE) ? 4'h0 : rnd[11:8]);
      trig_r.unit2 <= rnd[12] | (i == 0);
      adc_en_r <= rnd[13] | (i == 0);
      p = pulses;
      wr(tmr_pkg::ADR_HIGH, h);
      wr(tmr_pkg::ADR_LOW, 8'h00);
      wr(tmr_pkg::ADR_CTL, 8'h01);
      bus(1'b0, tmr_pkg::ADR_FLG, 8'h00, 1'b1);
      wr(tmr_pkg::ADR_CTL, 8'h00);
      rc(tmr_pkg::ADR_HIGH, "trig high", (i < 2) ? 8'h00 : h);
      chk("adc pulses", 8'(pulses - p), {7'h0, i < 2 && trig_r.unit2 && adc_en_r});
      rc(tmr_pkg::ADR_FLG, "flag after trig", 8'h00);
    end
    // counter write on the same edge as a trigger keeps the written value
    trig_r.mode <= tmr_pkg::SEV_MODE;
    wr(tmr_pkg::ADR_HIGH, 8'h5a);
    bus(1'b1, tmr_pkg::ADR_LOW, 8'h3c, 1'b1);
    rc(tmr_pkg::ADR_LOW, "write vs trig low", 8'h3c);
    rc(tmr_pkg::ADR_HIGH, "write vs trig high", 8'h5a);
    // 16-bit access through the high byte buffer
    wr(tmr_pkg::ADR_CTL, 8'h80);
    wr(tmr_pkg::ADR_HIGH, 8'hab);
    wr(tmr_pkg::ADR_LOW, 8'hcd);
    wr(tmr_pkg::ADR_HIGH, 8'h11);
    rc(tmr_pkg::ADR_LOW, "low 16-bit", 8'hcd);
    rc(tmr_pkg::ADR_HIGH, "high snapshot", 8'hab);
    // external edges through each prescale, high write in mid-count
    for (int ps = 0; ps < 4; ps++) begin
      wr(tmr_pkg::ADR_CTL, 8'h03 | 8'(ps << 4));
      wr(tmr_pkg::ADR_HIGH, 8'h00);
      wr(tmr_pkg::ADR_LOW, 8'h00);
      for (int i = 0; i < 16; i++) begin
        if (i == 6) wr(tmr_pkg::ADR_HIGH, 8'h00);
        ext(1'b1);
        ext(1'b0);
      end
      rc(tmr_pkg::ADR_LOW, "prescaled", 8'(16 >> ps));
    end
    // async mode: update while input low skips the next rise; trigger reset ignored
    wr(tmr_pkg::ADR_CTL, 8'h07);
    wr(tmr_pkg::ADR_LOW, 8'h00);
    ext(1'b1);
    ext(1'b0);
    ext(1'b1);
    bus(1'b0, tmr_pkg::ADR_FLG, 8'h00, 1'b1);
    rc(tmr_pkg::ADR_LOW, "async count", 8'h01);
    // rtc use: oscillator source, async, irq on; preload near rollover for a short run
    use_osc = 1'b1;
    lps_r <= 1'b1;
    wr(tmr_pkg::ADR_CTL, 8'h0f);
    rc(tmr_pkg::ADR_CTL, "rtc config", 8'h4f);
    wr(tmr_pkg::ADR_ENA, 8'h01);
    wr(tmr_pkg::ADR_HIGH, 8'hff);
    wr(tmr_pkg::ADR_LOW, 8'hfd);
    ext(1'b1);
    for (int i = 0; i < 3; i++) begin
      ext(1'b0);
      ext(1'b1);
    end
    chk("rtc irq", {7'h0, irq_o}, 8'h01);
    // poll the low byte until it steps, then set the high msb while the input is high
    polls = 0;
    do begin
      ext(1'b0);
      ext(1'b1);
      bus(1'b0, tmr_pkg::ADR_LOW, 8'h00, 1'b0);
      polls++;
    end while (q[0] !== 1'b1 && polls < 4);
    chk("poll turns", 8'(polls), 8'h01);
    wr(tmr_pkg::ADR_HIGH, 8'h80);
    ext(1'b0);
    ext(1'b1);
    rc(tmr_pkg::ADR_LOW, "rtc low kept", 8'h02);
    rc(tmr_pkg::ADR_HIGH, "rtc high msb", 8'h80);
    rc(tmr_pkg::ADR_FLG, "rtc flag held", 8'h01);
    wrap_up();
  end
endmodule
